// ---- la_defs.svh ----
// Constants of the logic array: register offsets, field positions, resets.
// Assumes byte addresses on an 8-bit register port with 16-bit data.
// How it works
// RULE_01 - Thirty-two elements in four blocks of eight, local numbers 0 to 7.
// RULE_02 - Each element is a two-input lookup table plus an output flip-flop.
// RULE_03 - Four-bit function code selects one of sixteen two-input functions.
// RULE_04 - Code bits high to low give output for AB = 11, 10, 01, 00.
// RULE_05 - Even selector codes 00/01/10/11 pick local elements 0, 2, 4, 6.
// RULE_06 - Local element 0 takes element 7 of the previous block on code 00.
// RULE_07 - Odd selector codes 00/01/10/11 pick local elements 1, 3, 5, 7.
// RULE_08 - Blocks 0 and 1: A alternative is the element's software input bit.
// RULE_09 - Blocks 2 and 3: A alternative is the output of element n-16.
// RULE_10 - A select 0 takes the alternative, 1 takes the even selector.
// RULE_11 - B select 0 takes odd feedback, 1 the pin; upper blocks always odd.
// RULE_12 - Pin inputs feed their elements whatever the pin function setting.
// RULE_13 - Pin inputs map to elements 0-7, 8, 10, 12-15.
// RULE_14 - Elements 2-5, 10-13, 18, 20, 21, 26, 27, 29 drive output pins.
// RULE_15 - Software assigns the 28 array pins to the array before use.
// RULE_16 - Element outputs reach interrupts, readback words and output pins.
// RULE_17 - Flip-flops bypass singly; one selectable clock source per block.
// RULE_18 - Output select 0 shows the flip-flop, 1 the raw table output.
// RULE_19 - Four enabled level interrupts, each following any chosen element.
// RULE_20 - For an active-low interrupt software programs an inverter element.
// RULE_21 - For an edge interrupt software builds a two-element edge detector.
// RULE_22 - Reset clears all configuration and flip-flops to zero.
// RULE_23 - Processor writes configuration; it takes effect the next cycle.
`ifndef LA_DEFS_SVH
`define LA_DEFS_SVH

`define LA_ELEM_BASE      8'h00
`define LA_ELEM_LAST      8'h7c
`define LA_CLKSEL_OFS     8'h80
`define LA_IRQSEL_LO_OFS  8'h84
`define LA_IRQSEL_HI_OFS  8'h88
`define LA_SWIN_OFS       8'h90
`define LA_RDBK0_OFS      8'h98
`define LA_RDBK1_OFS      8'h9c
`define LA_LOCK_OFS       8'ha0
`define LA_SWTICK_OFS     8'ha4

`define LA_CFG_W          11
`define LA_F_EVEN_HI      10
`define LA_F_EVEN_LO      9
`define LA_F_ODD_HI       8
`define LA_F_ODD_LO       7
`define LA_F_ASEL         6
`define LA_F_BSEL         5
`define LA_F_LUT_HI       4
`define LA_F_LUT_LO       1
`define LA_F_BYP          0

`define LA_IRQ_IDX_W      5
`define LA_IRQ_EN_BIT     5
`define LA_IRQ_FIELD_W    8
`define LA_CLKSEL_W       3
`define LA_CLKSEL_FIELD_W 4

`define LA_CFG_RST        11'h000
`define LA_CLKSEL_RST     16'h0000
`define LA_IRQSEL_RST     16'h0000
`define LA_SWIN_RST       16'h0000

`endif

// ---- la_pkg.sv ----
// Types shared by the logic array modules.
// Assumes la_defs.svh supplies the numeric constants.
`default_nettype none
package la_pkg;
    // Clock source of one block's output flip-flops.
    typedef enum logic [2:0] {
        LA_CLK_SYS  = 3'h0,
        LA_CLK_RISE = 3'h1,
        LA_CLK_FALL = 3'h2,
        LA_CLK_SW   = 3'h3,
        LA_CLK_STOP = 3'h4
    } la_clk_src_t;
endpackage
`default_nettype wire

// ---- la_element.sv ----
// One array element: input selectors, lookup table, output flip-flop.
// Assumes the parent gives it its block's outputs and a per-block tick.
`include "la_defs.svh"
`default_nettype none
module la_element #(
    parameter bit FIRST_IN_BLOCK = 1'b0,
    parameter bit PIN_ALLOWED    = 1'b1
) (
    input  wire logic                 mclk,
    input  wire logic                 rstn,
    input  wire logic                 ce,
    input  wire logic [`LA_CFG_W-1:0] cfg,
    input  wire logic [7:0]           blockOut,
    input  wire logic                 ringIn,
    input  wire logic                 altA,
    input  wire logic                 pinIn,
    input  wire logic                 tick,
    output logic                      elemOut
);
    logic [1:0] evenCode;
    logic [1:0] oddCode;
    logic       evenVal;
    logic       oddVal;
    logic       aVal;
    logic       bVal;
    logic       lutVal;
    logic       ff_q;
    logic [3:0] lutCode;

    assign evenCode = cfg[`LA_F_EVEN_HI:`LA_F_EVEN_LO];
    assign oddCode  = cfg[`LA_F_ODD_HI:`LA_F_ODD_LO];
    assign lutCode  = cfg[`LA_F_LUT_HI:`LA_F_LUT_LO];

    // Selectors feeding the two table inputs.
    always_comb begin
        if (evenCode == 2'h0 && FIRST_IN_BLOCK) begin
            evenVal = ringIn; // [RULE_06]
        end else begin
            evenVal = blockOut[{evenCode, 1'b0}]; // [RULE_05]
        end
        oddVal = blockOut[{oddCode, 1'b1}]; // [RULE_07]
        aVal = cfg[`LA_F_ASEL] ? evenVal : altA; // [RULE_10]
        bVal = (cfg[`LA_F_BSEL] && PIN_ALLOWED) ? pinIn : oddVal; // [RULE_11]
    end

    // The code itself is the truth table, indexed by {A,B}.
    assign lutVal = lutCode[{aVal, bVal}]; // [RULE_02] [RULE_03] [RULE_04]

    // The flip-flop only moves on its block's tick.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ff_q <= 1'b0; // [RULE_22]
        end else if (ce && tick) begin
            ff_q <= lutVal; // [RULE_17]
        end
    end

    // Bypass shows the raw table; this can close a loop through feedback.
    assign elemOut = cfg[`LA_F_BYP] ? lutVal : ff_q; // [RULE_18]
endmodule // la_element
`default_nettype wire

// ---- la_logic_array.sv ----
// Top of the logic array: register port, pins, clock ticks, interrupts.
// Assumes pins and extClk are asynchronous; the register port is on mclk.
//
// Implementation choices: the address map and the address-and-strobe port.
`include "la_defs.svh"
`default_nettype none
module la_logic_array (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic [7:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [15:0] regRdata,
    input  wire logic [13:0] gpioIn,
    input  wire logic        extClk,
    output logic      [13:0] gpioOut,
    output logic      [3:0]  irqOut
);
    logic [`LA_CFG_W-1:0] cfg_q [32];
    logic [15:0]          clkSel_q;
    logic [15:0]          irqSelLo_q;
    logic [15:0]          irqSelHi_q;
    logic [15:0]          swIn_q;
    logic                 lock_q;
    logic [13:0]          pinMeta_q;
    logic [13:0]          pinSync_q;
    logic [2:0]           extSync_q;
    logic                 extRise;
    logic                 extFall;
    logic [3:0]           swTick_q;
    logic [3:0]           tick;
    logic [31:0]          elemOut;
    logic [15:0]          rdata_q;
    logic [13:0]          pinOut_q;
    logic [3:0]           irq_q;
    logic [31:0]          irqSrc;
    logic [31:0]          rdbk;
    logic                 cfgWrite;

    // Pin bit that feeds element e, or 14 when it has no pin input.
    function automatic logic [3:0] pinOf(input int e);
        if (e < 8) begin
            pinOf = 4'(e);
        end else if (e == 8) begin
            pinOf = 4'h8;
        end else if (e == 10) begin
            pinOf = 4'h9;
        end else if (e >= 12 && e < 16) begin
            pinOf = 4'(e - 2);
        end else begin
            pinOf = 4'he;
        end
    endfunction

    // Element that drives output pin p.
    function automatic logic [4:0] outElemOf(input int p);
        case (p)
            0: outElemOf = 5'h02;
            1: outElemOf = 5'h03;
            2: outElemOf = 5'h04;
            3: outElemOf = 5'h05;
            4: outElemOf = 5'h0a;
            5: outElemOf = 5'h0b;
            6: outElemOf = 5'h0c;
            7: outElemOf = 5'h0d;
            8: outElemOf = 5'h12;
            9: outElemOf = 5'h14;
            10: outElemOf = 5'h15;
            11: outElemOf = 5'h1a;
            12: outElemOf = 5'h1b;
            default: outElemOf = 5'h1d;
        endcase
    endfunction

    // Element writes are dropped once the lock is set.
    assign cfgWrite = regWr && !lock_q && (regAddr <= `LA_ELEM_LAST);

    // Element configuration words.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            for (int i = 0; i < 32; i++) begin
                cfg_q[i] <= `LA_CFG_RST; // [RULE_22]
            end
        end else if (ce && cfgWrite) begin
            cfg_q[regAddr[6:2]] <= regWdata[`LA_CFG_W-1:0]; // [RULE_23]
        end
    end

    // Clock select, interrupt select and software input words.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            clkSel_q   <= `LA_CLKSEL_RST;
            irqSelLo_q <= `LA_IRQSEL_RST;
            irqSelHi_q <= `LA_IRQSEL_RST;
            swIn_q     <= `LA_SWIN_RST;
        end else if (ce && regWr && !lock_q) begin
            case (regAddr)
                `LA_CLKSEL_OFS: clkSel_q <= regWdata;
                `LA_IRQSEL_LO_OFS: irqSelLo_q <= regWdata;
                `LA_IRQSEL_HI_OFS: irqSelHi_q <= regWdata;
                default: ;
            endcase
        end
        // The input word stays writable under lock; it is live data.
        if (rstn && ce && regWr && regAddr == `LA_SWIN_OFS) begin
            swIn_q <= regWdata;
        end
    end

    // Lock sets once on a write with bit 0 set and clears only on reset.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            lock_q <= 1'b0;
        end else if (ce && regWr && regAddr == `LA_LOCK_OFS &&
                     regWdata[0]) begin
            lock_q <= 1'b1;
        end
    end

    // Pins and the external clock are asynchronous: two stages for the pins, three for extClk.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pinMeta_q <= 14'h0000;
            pinSync_q <= 14'h0000;
            extSync_q <= 3'h0;
        end else if (ce) begin
            pinMeta_q <= gpioIn;
            pinSync_q <= pinMeta_q; // [RULE_12]
            extSync_q <= {extSync_q[1:0], extClk};
        end
    end

    // Software tick: a write of bit b to the tick word pulses block b.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            swTick_q <= 4'h0;
        end else if (ce) begin
            swTick_q <= 4'h0;
            if (regWr && regAddr == `LA_SWTICK_OFS) begin
                swTick_q <= regWdata[3:0];
            end
        end
    end

    // Edges use only the second and third sync stages, never the first.
    assign extRise = extSync_q[1] & ~extSync_q[2];
    assign extFall = ~extSync_q[1] & extSync_q[2];

    // Per-block tick chosen by each block's clock select field.
    generate
        for (genvar b = 0; b < 4; b++) begin : g_tick
            la_pkg::la_clk_src_t src;
            assign src = la_pkg::la_clk_src_t'(
                clkSel_q[b*`LA_CLKSEL_FIELD_W +: `LA_CLKSEL_W]);
            always_comb begin
                case (src)
                    la_pkg::LA_CLK_SYS:  tick[b] = 1'b1; // [RULE_17]
                    la_pkg::LA_CLK_RISE: tick[b] = extRise;
                    la_pkg::LA_CLK_FALL: tick[b] = extFall;
                    la_pkg::LA_CLK_SW:   tick[b] = swTick_q[b];
                    default:             tick[b] = 1'b0;
                endcase
            end
        end
    endgenerate

    // Thirty-two elements, block b holding elements 8b to 8b+7.
    generate
        for (genvar e = 0; e < 32; e++) begin : g_elem // [RULE_01]
            localparam int BLK = e / 8;
            localparam int LOC = e % 8;
            localparam int RING = ((BLK + 3) % 4) * 8 + 7;
            logic altA;
            logic pinVal;
            if (BLK < 2) begin : g_lo
                assign altA = swIn_q[e]; // [RULE_08]
            end else begin : g_hi
                assign altA = elemOut[e-16]; // [RULE_09]
            end
            if (pinOf(e) != 4'he) begin : g_pin
                assign pinVal = pinSync_q[pinOf(e)]; // [RULE_13]
            end else begin : g_nopin
                assign pinVal = 1'b0;
            end
            la_element #(
                .FIRST_IN_BLOCK (LOC == 0),
                .PIN_ALLOWED    (e < 16)
            ) u_elem (
                .mclk     (mclk),
                .rstn     (rstn),
                .ce       (ce),
                .cfg      (cfg_q[e]),
                .blockOut (elemOut[BLK*8 +: 8]),
                .ringIn   (elemOut[RING]), // [RULE_06]
                .altA     (altA),
                .pinIn    (pinVal),
                .tick     (tick[BLK]),
                .elemOut  (elemOut[e])
            );
        end
    endgenerate

    // Readback words mirror live element outputs.
    assign rdbk = elemOut; // [RULE_16]

    // Output pins are registered so they never glitch on a table change.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pinOut_q <= 14'h0000;
        end else if (ce) begin
            for (int p = 0; p < 14; p++) begin
                pinOut_q[p] <= elemOut[outElemOf(p)]; // [RULE_14]
            end
        end
    end
    assign gpioOut = pinOut_q;

    // Interrupt sources: one select byte per line, index plus enable.
    always_comb begin
        irqSrc = {irqSelHi_q, irqSelLo_q};
    end

    // Level interrupts follow the chosen element while enabled.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            irq_q <= 4'h0;
        end else if (ce) begin
            for (int q = 0; q < 4; q++) begin
                irq_q[q] <= irqSrc[q*`LA_IRQ_FIELD_W + `LA_IRQ_EN_BIT] &
                    elemOut[irqSrc[q*`LA_IRQ_FIELD_W +: `LA_IRQ_IDX_W]];
            end // [RULE_19]
        end
    end
    assign irqOut = irq_q;

    // Read data one cycle after the strobe; unmapped reads return zero.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rdata_q <= 16'h0000;
        end else if (ce) begin
            rdata_q <= 16'h0000;
            if (regRd) begin
                if (regAddr <= `LA_ELEM_LAST && regAddr[1:0] == 2'h0) begin
                    rdata_q <= {5'h00, cfg_q[regAddr[6:2]]};
                end else begin
                    case (regAddr)
                        `LA_CLKSEL_OFS:    rdata_q <= clkSel_q;
                        `LA_IRQSEL_LO_OFS: rdata_q <= irqSelLo_q;
                        `LA_IRQSEL_HI_OFS: rdata_q <= irqSelHi_q;
                        `LA_SWIN_OFS:      rdata_q <= swIn_q;
                        `LA_RDBK0_OFS:     rdata_q <= rdbk[15:0];
                        `LA_RDBK1_OFS:     rdata_q <= rdbk[31:16];
                        `LA_LOCK_OFS:      rdata_q <= {15'h0000, lock_q};
                        default:           rdata_q <= 16'h0000;
                    endcase
                end
            end
        end
    end
    assign regRdata = rdata_q;
endmodule // la_logic_array
`default_nettype wire

// ---- la_props.sv ----
// Assertions on the ports of the logic array top.
// Assumes a bind onto la_logic_array from tb_top; ce drops only briefly.
`default_nettype none
module la_props (
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        ce,
    input wire logic [7:0]  regAddr,
    input wire logic [15:0] regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [15:0] regRdata,
    input wire logic [13:0] gpioIn,
    input wire logic        extClk,
    input wire logic [13:0] gpioOut,
    input wire logic [3:0]  irqOut
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cfgSeen_q, irqSeen_q, lock_q;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // Remember what software touched since reset; the rest must stay idle.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cfgSeen_q <= 1'b0;
            irqSeen_q <= 1'b0;
            lock_q <= 1'b0;
        end else if (regWr) begin
            if (regAddr <= 8'h7c) cfgSeen_q <= 1'b1;
            if ((regAddr == 8'h84 || regAddr == 8'h88) &&
                (regWdata[5] || regWdata[13])) irqSeen_q <= 1'b1;
            if (regAddr == 8'ha0 && regWdata[0]) lock_q <= 1'b1;
        end
    end
    // A write followed at once by a read of the same place.
    sequence swWrRd;
        regWr && regAddr == 8'h90 ##1 regRd && regAddr == 8'h90;
    endsequence
    sequence cfgWrRd;
        regWr && regAddr <= 8'h7c && regAddr[1:0] == 2'b00 && !lock_q
        ##1 regRd && regAddr == $past(regAddr);
    endsequence
    chk_rd_idle: assert property (
        !$past(regRd) |-> regRdata == 16'h0000)
        else $error("read data outside its slot");
    chk_reset_clr: assert property (disable iff (1'b0)
        !rstn |=> gpioOut == 14'h0000 && irqOut == 4'h0 && !regRdata)
        else $error("outputs not cleared by reset");
    chk_irq_quiet: assert property (
        !irqSeen_q |-> irqOut == 4'h0)
        else $error("interrupt without enable");
    chk_pin_quiet: assert property (
        !cfgSeen_q |-> gpioOut == 14'h0000)
        else $error("pin output before any element setup");
    chk_rdbk_zero: assert property (
        regRd && regAddr[7:3] == 5'h13 && !cfgSeen_q |=> !regRdata)
        else $error("output word not zero after reset");
    chk_sw_echo: assert property (
        swWrRd |=> regRdata == $past(regWdata, 2))
        else $error("software input word not read back");
    chk_cfg_echo: assert property (
        cfgWrRd |=> regRdata == ($past(regWdata, 2) & 16'h07ff))
        else $error("element setup not in effect next cycle");
    chk_unmapped: assert property (
        regRd && regAddr == 8'hfc |=> regRdata == 16'h0000)
        else $error("unmapped read not zero");
endmodule // la_props
`default_nettype wire

// ---- la_pin_model.sv ----
// Far side of the logic array: input pads and the external clock.
// Assumes the bench sets pad levels and when the clock should run.
`default_nettype none
module la_pin_model (
    input  wire logic        mclk,
    input  wire logic [13:0] pinSet,
    input  wire logic        extRun,
    output var logic  [13:0] gpioIn,
    output var logic         extClk
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] div_q = 3'h0;
    // Every pad is taken as already handed to the array.
    // Pads settle off the edge, as asynchronous inputs really do.
    initial gpioIn = 14'h0000;
    always @(posedge mclk) gpioIn <= #3 pinSet;
    // Slow clock runs only when asked and rests low in between.
    initial extClk = 1'b0;
    always @(posedge mclk) begin
        div_q <= extRun ? div_q + 3'h1 : 3'h0;
        extClk <= #2 extRun & div_q[2];
    end
endmodule // la_pin_model
`default_nettype wire

// ---- tb_top.sv ----
// Bench of the logic array through its register port, pins and irqs.
// Assumes la_props.sv and la_pin_model.sv are compiled first.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, rstn, ce, regWr, regRd, extRun, extClk;
    logic [7:0]  regAddr;
    logic [15:0] regWdata, regRdata, lastRd;
    logic [13:0] gpioIn, pinSet, gpioOut;
    logic [3:0]  irqOut;
    int          fail_count = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          outEl [14] = '{2, 3, 4, 5, 10, 11, 12, 13, 18, 20, 21,
                                26, 27, 29};
    la_logic_array u_dut (.mclk(mclk), .rstn(rstn), .ce(ce),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .gpioIn(gpioIn),
        .extClk(extClk), .gpioOut(gpioOut), .irqOut(irqOut));
    la_pin_model u_pins (.mclk(mclk), .pinSet(pinSet), .extRun(extRun),
        .gpioIn(gpioIn), .extClk(extClk));
    // Clock, and a ceiling on the run well above the roughly 900 cycles.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic chk(input string n, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // One bus cycle; lastRd keeps the data of the slot just ended.
    task automatic cyc(input logic w, r, input logic [7:0] a,
                       input logic [15:0] d);
        @(posedge mclk);
        lastRd = regRdata;
        regWr <= w;
        regRd <= r;
        regAddr <= a;
        regWdata <= d;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        cyc(1'b1, 1'b0, a, d);
    endtask
    task automatic idle(input int n);
        repeat (n) cyc(1'b0, 1'b0, 8'h00, 16'h0000);
    endtask
    task automatic rd(input logic [7:0] a);
        cyc(1'b0, 1'b1, a, 16'h0000);
        idle(2);
    endtask
    task automatic rdb(input logic [7:0] a, input string n, input logic e);
        rd(a);
        chk(n, {15'h0000, lastRd[0]}, {15'h0000, e});
    endtask
    // First and last element words, every other readable register and an unmapped place read zero after reset.
    task automatic t_reset();
        logic [7:0] ra [10] = '{8'h00, 8'h7c, 8'h80, 8'h84, 8'h88, 8'h90,
                                8'h98, 8'h9c, 8'ha0, 8'hfc};
        foreach (ra[i]) begin
            rd(ra[i]);
            chk("reset read", lastRd, 16'h0000);
        end
    endtask
    // Every table code against all four input pairs; B comes from a pad.
    task automatic t_lut();
        logic [15:0] cfg;
        for (int c = 0; c < 16; c++) begin
            cfg = 16'h0021 | (16'(c) << 1);
            wr(8'h00, cfg);
            rd(8'h00);
            chk("cfg word", lastRd, cfg);
            for (int p = 0; p < 4; p++) begin
                wr(8'h90, 16'(p / 2));
                pinSet <= 14'(p % 2);
                idle(4);
                rdb(8'h98, "table", c[p]);
            end
        end
        wr(8'h00, 16'h0000);
    endtask
    // Walk a one over the eight low-block pad sources; the upper six pads follow n-16.
    task automatic t_pins();
        logic [15:0] sw;
        logic [13:0] pin;
        foreach (outEl[i]) wr(8'(outEl[i] * 4), 16'h0019);
        for (int b = 0; b < 8; b++) begin
            sw = 16'h0001 << outEl[b];
            wr(8'h90, sw);
            rd(8'h90);
            chk("sw word", lastRd, sw);
            foreach (outEl[i]) pin[i] = sw[outEl[i] % 16];
            chk("pads", {2'b00, gpioOut}, {2'b00, pin});
            rd(8'h98);
            chk("low word", lastRd, sw & 16'h3c3c);
            rd(8'h9c);
            chk("high word", lastRd, sw & 16'h2c34);
        end
    endtask
    // Element 16 samples each even and odd source, ring input included.
    task automatic t_fb();
        int ev [4] = '{15, 2, 4, 6};
        int src;
        logic [15:0] cfg, sw;
        for (int e = 1; e < 8; e++) begin
            wr(8'(e * 4), 16'h0019);
            wr(8'(e * 4 + 64), 16'h0019);
        end
        wr(8'h3c, 16'h0019);
        for (int m = 0; m < 16; m++) begin
            src = m[2] ? 2 * (m % 4) + 1 : ev[m % 4];
            cfg = m[2] ? 16'h0015 | (16'(m % 4) << 7)
                       : 16'h0059 | (16'(m % 4) << 9);
            sw = 16'h0001 << src;
            wr(8'h40, cfg);
            wr(8'h90, m[3] ? ~sw : sw);
            rdb(8'h9c, "fb", !m[3]);
        end
    endtask
    // Flip-flop held, bypassed, ticked by software and by the pad clock.
    task automatic t_clock();
        wr(8'h00, 16'h0018);
        wr(8'h90, 16'h0000);
        wr(8'h80, 16'h0004);
        idle(2);
        wr(8'h90, 16'h0001);
        rdb(8'h98, "ff held", 1'b0);
        wr(8'h00, 16'h0019);
        rdb(8'h98, "bypass", 1'b1);
        wr(8'h00, 16'h0018);
        wr(8'h80, 16'h0003);
        wr(8'ha4, 16'h0001);
        idle(1);
        rdb(8'h98, "sw tick", 1'b1);
        wr(8'h90, 16'h0000);
        wr(8'h80, 16'h0001);
        rdb(8'h98, "ext still", 1'b1);
        extRun <= 1'b1;
        idle(30);
        extRun <= 1'b0;
        rdb(8'h98, "ext run", 1'b0);
        wr(8'h80, 16'h0000);
    endtask
    // Level irqs, one on an inverter element, then two of them masked.
    task automatic t_irq();
        logic [15:0] ex;
        wr(8'h00, 16'h0019);
        wr(8'h04, 16'h0007);
        wr(8'h40, 16'h0019);
        wr(8'h84, 16'h2120);
        wr(8'h88, 16'h3030);
        for (int s = 0; s < 2; s++) begin
            wr(8'h90, s ? 16'h0003 : 16'h0000);
            idle(3);
            ex = s ? 16'h000d : 16'h0002;
            chk("irq", {12'h000, irqOut}, ex);
        end
        wr(8'h84, 16'h0100);
        idle(3);
        chk("irq masked", {12'h000, irqOut}, 16'h000c);
        // Edge irq: element 3 keeps a registered copy, element 4 finds rises.
        wr(8'h0c, 16'h0058);
        wr(8'h10, 16'h00c9);
        wr(8'h88, 16'h2430);
        wr(8'h90, 16'h0000);
        idle(2);
        wr(8'h90, 16'h0001);
        idle(3);
        chk("edge irq", {12'h000, irqOut}, 16'h000c);
        idle(1);
        chk("edge irq end", {12'h000, irqOut}, 16'h0004);
    endtask
    // A second reset in mid-run with interrupts and pads active.
    task automatic t_rst2();
        wr(8'h84, 16'h0020);
        wr(8'h90, 16'h0001);
        idle(3);
        chk("irq before", {12'h000, irqOut}, 16'h0005);
        // With ce low a write is not taken.
        ce <= 1'b0;
        wr(8'h90, 16'h0000);
        idle(1);
        ce <= 1'b1;
        rd(8'h90);
        chk("ce freeze", lastRd, 16'h0001);
        // Once locked, element setup ignores writes.
        wr(8'ha0, 16'h0001);
        wr(8'h00, 16'h0000);
        rdb(8'ha0, "lock", 1'b1);
        rd(8'h00);
        chk("locked cfg", lastRd, 16'h0019);
        rstn <= 1'b0;
        idle(2);
        rstn <= 1'b1;
        chk("reset irq", {12'h000, irqOut}, 16'h0000);
        rd(8'h00);
        chk("reset cfg", lastRd, 16'h0000);
        rdb(8'ha0, "lock clear", 1'b0);
    endtask
    task automatic final_report();
        if (fail_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Main sequence.
    initial begin
        rstn = 1'b0;
        {regWr, regRd, extRun, regAddr, regWdata, pinSet} = '0;
        ce = 1'b1;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        t_reset();
        t_lut();
        t_pins();
        t_fb();
        t_clock();
        t_irq();
        t_rst2();
        final_report();
    end
endmodule // tb_top
bind la_logic_array la_props u_props (.mclk(mclk), .rstn(rstn), .ce(ce),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .gpioIn(gpioIn),
    .extClk(extClk), .gpioOut(gpioOut), .irqOut(irqOut));
`default_nettype wire
